//--- rtl/midrange_instruction_decoder.sv
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "midrange_core_regs.svh"

module midrange_instruction_decoder (
    input wire logic clk, // 50 MHz clock
    input wire logic rst_n, // synchronous reset, active low
    output logic [12:0] prog_addr, // program memory address
    input wire midrange_core_pkg::word_t prog_data, // instruction word
    output logic [6:0] file_addr, // file register address
    input wire midrange_core_pkg::byte_t file_rdata, // file read data
    output logic [7:0] file_wdata, // file write data
    output logic file_we, // file write strobe
    input wire midrange_core_pkg::byte_t port_pins, // port pin levels
    input wire logic psc_to_timer0, // prescaler assigned to timer0
    output logic psc_clear, // prescaler clear pulse
    output logic sleep_req, // standby entry pulse
    output logic wdt_clear, // watchdog clear pulse
    input wire midrange_core_pkg::bus_addr_t reg_addr, // register address
    input wire midrange_core_pkg::bus_data_t reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [15:0] reg_rdata // read data, cycle after strobe
);
    import midrange_core_pkg::*;

    core_s st_q;
    core_s st_d;

    faddr_t f_fld;
    logic d_fld;
    logic [2:0] b_fld;
    byte_t k_fld;
    byte_t opnd;
    byte_t res;
    byte_t mask;
    logic [9:0] sum;
    logic wr_reg;
    logic wr_acc;
    logic skip;
    logic jump;
    paddr_t target;

    // Returns {carry, half carry, sum}.
    function automatic logic [9:0] alu_add(input byte_t a,
                                           input byte_t b,
                                           input logic ci);
        logic [4:0] lo;
        logic [8:0] s;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        return {s[8], lo[4], s[7:0]};
    endfunction : alu_add

    always_comb begin
        st_d = st_q;
        st_d.file_we = 1'b0;
        st_d.sleep_p = 1'b0;
        st_d.wdt_p = 1'b0;
        st_d.psc_clr = 1'b0;
        st_d.rd_data = 16'h0000;

        // Pin synchroniser; a bit changes once stages two and three agree.
        st_d.pin1 = port_pins;
        st_d.pin2 = st_q.pin1;
        st_d.pin3 = st_q.pin2;
        for (int i = 0; i < 8; i++) begin
            if (st_q.pin2[i] == st_q.pin3[i]) begin
                st_d.pin_ok[i] = st_q.pin3[i];
            end
        end

        f_fld = st_q.ir[6:0];
        d_fld = st_q.ir[7];
        b_fld = st_q.ir[9:7];
        k_fld = st_q.ir[7:0];
        mask = 8'h01 << b_fld;
        // Read-modify-write of the port sees the pins, not the latch.
        opnd = (f_fld == `IO_PORT_ADDR) ? st_q.pin_ok : file_rdata;
        res = opnd;
        sum = 10'h000;
        wr_reg = 1'b0;
        wr_acc = 1'b0;
        skip = 1'b0;
        jump = 1'b0;
        target = st_q.pc;

        // Four phases make one instruction cycle.
        case (st_q.phase)
            PH_Q1: begin
                if (st_q.run) begin
                    st_d.phase = PH_Q2;
                    // A flushed slot runs as a no-op and keeps the PC.
                    if (st_q.flush) begin
                        st_d.ir = 14'h0000;
                        st_d.hold_pc = 1'b1;
                        st_d.flush = 1'b0;
                    end else begin
                        st_d.ir = prog_data;
                        st_d.hold_pc = 1'b0;
                    end
                    st_d.file_addr = prog_data[6:0];
                end
            end
            PH_Q2: begin
                st_d.phase = PH_Q3;
            end
            PH_Q3: begin
                st_d.phase = PH_Q4;
                // Don't-care positions are wildcards here.
                casez (st_q.ir)
                    14'b00_0111_????????: begin
                        sum = alu_add(opnd, st_q.acc, 1'b0);
                        res = sum[7:0];
                        st_d.c = sum[9];
                        st_d.dc = sum[8];
                        st_d.z = (res == 8'h00);
                        wr_reg = d_fld;
                        wr_acc = !d_fld;
                    end
                    14'b00_0010_????????: begin
                        sum = alu_add(opnd, ~st_q.acc, 1'b1);
                        res = sum[7:0];
                        st_d.c = sum[9];
                        st_d.dc = sum[8];
                        st_d.z = (res == 8'h00);
                        wr_reg = d_fld;
                        wr_acc = !d_fld;
                    end
                    14'b00_0101_????????, 14'b00_0100_????????,
                    14'b00_0110_????????: begin
                        case (st_q.ir[11:8])
                            4'h5: res = opnd & st_q.acc;
                            4'h4: res = opnd | st_q.acc;
                            default: res = opnd ^ st_q.acc;
                        endcase
                        st_d.z = (res == 8'h00);
                        wr_reg = d_fld;
                        wr_acc = !d_fld;
                    end
                    14'b00_1011_????????, 14'b00_1111_????????: begin
                        res = st_q.ir[10] ? opnd + 8'h01 : opnd - 8'h01;
                        skip = (res == 8'h00);
                        wr_reg = d_fld;
                        wr_acc = !d_fld;
                    end
                    14'b00_0011_????????, 14'b00_1010_????????,
                    14'b00_1001_????????, 14'b00_1000_????????: begin
                        case (st_q.ir[11:8])
                            4'h3: res = opnd - 8'h01;
                            4'hA: res = opnd + 8'h01;
                            4'h9: res = ~opnd;
                            default: res = opnd;
                        endcase
                        st_d.z = (res == 8'h00);
                        wr_reg = d_fld;
                        wr_acc = !d_fld;
                    end
                    14'b00_1101_????????: begin
                        res = {opnd[6:0], st_q.c};
                        st_d.c = opnd[7];
                        wr_reg = d_fld;
                        wr_acc = !d_fld;
                    end
                    14'b00_1100_????????: begin
                        res = {st_q.c, opnd[7:1]};
                        st_d.c = opnd[0];
                        wr_reg = d_fld;
                        wr_acc = !d_fld;
                    end
                    14'b00_1110_????????: begin
                        res = {opnd[3:0], opnd[7:4]};
                        wr_reg = d_fld;
                        wr_acc = !d_fld;
                    end
                    14'b00_0001_????????: begin
                        res = 8'h00;
                        st_d.z = 1'b1;
                        wr_reg = d_fld;
                        wr_acc = !d_fld;
                    end
                    14'b00_0000_1???????: begin
                        res = st_q.acc;
                        wr_reg = 1'b1;
                    end
                    14'b00_0000_0000_1000: begin
                        jump = 1'b1;
                        target = st_q.stack[st_q.sp - 3'h1];
                        st_d.sp = st_q.sp - 3'h1;
                    end
                    14'b00_0000_0000_1001: begin
                        jump = 1'b1;
                        target = st_q.stack[st_q.sp - 3'h1];
                        st_d.sp = st_q.sp - 3'h1;
                        st_d.gie = 1'b1;
                    end
                    14'b00_0000_0110_0011: begin
                        st_d.to = 1'b1;
                        st_d.pd = 1'b0;
                        st_d.sleep_p = 1'b1;
                    end
                    14'b00_0000_0110_0100: begin
                        st_d.to = 1'b1;
                        st_d.pd = 1'b1;
                        st_d.wdt_p = 1'b1;
                    end
                    14'b01_00??_????????: begin
                        res = opnd & ~mask;
                        wr_reg = 1'b1;
                    end
                    14'b01_01??_????????: begin
                        res = opnd | mask;
                        wr_reg = 1'b1;
                    end
                    14'b01_10??_????????: begin
                        skip = ((opnd & mask) == 8'h00);
                    end
                    14'b01_11??_????????: begin
                        skip = ((opnd & mask) != 8'h00);
                    end
                    14'b10_0???_????????: begin
                        jump = 1'b1;
                        target = {st_q.pc[12:11], st_q.ir[10:0]};
                        st_d.stack[st_q.sp] = st_q.pc + 13'h0001;
                        st_d.sp = st_q.sp + 3'h1;
                    end
                    14'b10_1???_????????: begin
                        jump = 1'b1;
                        target = {st_q.pc[12:11], st_q.ir[10:0]};
                    end
                    14'b11_111?_????????: begin
                        sum = alu_add(k_fld, st_q.acc, 1'b0);
                        res = sum[7:0];
                        st_d.c = sum[9];
                        st_d.dc = sum[8];
                        st_d.z = (res == 8'h00);
                        wr_acc = 1'b1;
                    end
                    14'b11_110?_????????: begin
                        sum = alu_add(k_fld, ~st_q.acc, 1'b1);
                        res = sum[7:0];
                        st_d.c = sum[9];
                        st_d.dc = sum[8];
                        st_d.z = (res == 8'h00);
                        wr_acc = 1'b1;
                    end
                    14'b11_1001_????????, 14'b11_1000_????????,
                    14'b11_1010_????????: begin
                        case (st_q.ir[11:8])
                            4'h9: res = k_fld & st_q.acc;
                            4'h8: res = k_fld | st_q.acc;
                            default: res = k_fld ^ st_q.acc;
                        endcase
                        st_d.z = (res == 8'h00);
                        wr_acc = 1'b1;
                    end
                    14'b11_00??_????????: begin
                        res = k_fld;
                        wr_acc = 1'b1;
                    end
                    14'b11_01??_????????: begin
                        res = k_fld;
                        wr_acc = 1'b1;
                        jump = 1'b1;
                        target = st_q.stack[st_q.sp - 3'h1];
                        st_d.sp = st_q.sp - 3'h1;
                    end
                    // No-op and every unused encoding change nothing.
                    default: begin
                        res = opnd;
                    end
                endcase

                if (wr_acc) begin
                    st_d.acc = res;
                end
                if (wr_reg) begin
                    st_d.file_we = 1'b1;
                    st_d.file_wdata = res;
                    if (f_fld == `TIMER0_ADDR && psc_to_timer0) begin
                        st_d.psc_clr = 1'b1;
                    end
                end

                // PC moves in Q3 so the next word is ready by Q1.
                if (st_q.hold_pc) begin
                    st_d.pc = st_q.pc;
                end else if (jump) begin
                    st_d.pc = target;
                    st_d.flush = 1'b1;
                end else if (skip) begin
                    st_d.pc = st_q.pc + 13'h0002;
                    st_d.flush = 1'b1;
                end else begin
                    st_d.pc = st_q.pc + 13'h0001;
                end
            end
            PH_Q4: begin
                st_d.phase = PH_Q1;
            end
            default: begin
                st_d.phase = PH_Q1;
            end
        endcase

        if (reg_wr && reg_addr == `REG_CTRL) begin
            st_d.run = reg_wdata[`CTRL_RUN_BIT];
        end
        if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL: st_d.rd_data[`CTRL_RUN_BIT] = st_q.run;
                `REG_ACC: st_d.rd_data = {8'h00, st_q.acc};
                `REG_STATUS: begin
                    st_d.rd_data[`ST_C_BIT] = st_q.c;
                    st_d.rd_data[`ST_DC_BIT] = st_q.dc;
                    st_d.rd_data[`ST_Z_BIT] = st_q.z;
                    st_d.rd_data[`ST_PD_BIT] = st_q.pd;
                    st_d.rd_data[`ST_TO_BIT] = st_q.to;
                    st_d.rd_data[`ST_GIE_BIT] = st_q.gie;
                end
                `REG_PC: st_d.rd_data = {3'h0, st_q.pc};
                default: st_d.rd_data = 16'h0000;
            endcase
        end

        if (!rst_n) begin
            st_d = '0;
            st_d.phase = PH_Q1;
            st_d.pc = `PC_RESET;
            st_d.acc = `ACC_RESET;
            st_d.to = `TO_RESET;
            st_d.pd = `PD_RESET;
            st_d.run = `CTRL_RESET;
        end
    end

    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    assign prog_addr = st_q.pc;
    assign file_addr = st_q.file_addr;
    assign file_wdata = st_q.file_wdata;
    assign file_we = st_q.file_we;
    assign psc_clear = st_q.psc_clr;
    assign sleep_req = st_q.sleep_p;
    assign wdt_clear = st_q.wdt_p;
    assign reg_rdata = st_q.rd_data;

endmodule : midrange_instruction_decoder

`default_nettype wire

//--- shared/midrange_core_regs.svh
`ifndef MIDRANGE_CORE_REGS_SVH
`define MIDRANGE_CORE_REGS_SVH

// Register bus offsets.
`define REG_CTRL 3'h0
`define REG_ACC 3'h1
`define REG_STATUS 3'h2
`define REG_PC 3'h3

// Field positions.
`define CTRL_RUN_BIT 0
`define ST_C_BIT 0
`define ST_DC_BIT 1
`define ST_Z_BIT 2
`define ST_PD_BIT 3
`define ST_TO_BIT 4
`define ST_GIE_BIT 5

// Reset values.
`define CTRL_RESET 1'h1
`define PC_RESET 13'h0000
`define ACC_RESET 8'h00
`define TO_RESET 1'h1
`define PD_RESET 1'h1

// File map points with side effects.
`define TIMER0_ADDR 7'h01
`define IO_PORT_ADDR 7'h06

// Oscillator periods per instruction cycle.
`define OSC_PER_CYCLE 4

`endif

//--- shared/midrange_core_pkg.sv
package midrange_core_pkg;

    typedef logic [13:0] word_t;
    typedef logic [7:0] byte_t;
    typedef logic [6:0] faddr_t;
    typedef logic [12:0] paddr_t;
    typedef logic [2:0] bus_addr_t;
    typedef logic [15:0] bus_data_t;

    // One state per oscillator period of an instruction cycle.
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_e;

    typedef struct packed {
        phase_e phase;
        word_t ir;
        logic flush;
        logic hold_pc;
        paddr_t pc;
        paddr_t [7:0] stack;
        logic [2:0] sp;
        byte_t acc;
        logic c;
        logic dc;
        logic z;
        logic to;
        logic pd;
        logic gie;
        logic run;
        faddr_t file_addr;
        byte_t file_wdata;
        logic file_we;
        logic sleep_p;
        logic wdt_p;
        logic psc_clr;
        bus_data_t rd_data;
        byte_t pin1;
        byte_t pin2;
        byte_t pin3;
        byte_t pin_ok;
    } core_s;

endpackage : midrange_core_pkg

//--- verification/midrange_decoder_sva.sv
`timescale 1ns/100ps
`default_nettype none
module midrange_decoder_sva (
    input wire logic clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic [12:0] prog_addr, // program address
    input wire logic [6:0] file_addr, // file address
    input wire logic file_we, // file write strobe
    input wire logic psc_to_timer0, // prescaler owner
    input wire logic psc_clear, // prescaler clear
    input wire logic sleep_req, // standby pulse
    input wire logic wdt_clear, // watchdog pulse
    input wire midrange_core_pkg::bus_addr_t reg_addr, // bus address
    input wire logic reg_rd, // read strobe
    input wire logic [15:0] reg_rdata // read data
);
    import midrange_core_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // One file write per instruction cycle of four clocks.
    a_we_spacing: assert property (
        file_we |=> !file_we [*3]) else $error("file writes too close");
    a_pc_spacing: assert property (
        $changed(prog_addr) |=> $stable(prog_addr) [*3])
        else $error("program address moved early");
    a_addr_held: assert property (
        file_we |-> $stable(file_addr) && file_addr == $past(file_addr, 2))
        else $error("file address moved in cycle");
    a_psc_cause: assert property (
        psc_clear |-> file_we && file_addr == 7'h01 && psc_to_timer0)
        else $error("prescaler cleared without timer write");
    a_psc_effect: assert property (
        file_we && file_addr == 7'h01 && psc_to_timer0 |-> psc_clear)
        else $error("timer write left prescaler");
    a_sleep_alone: assert property (
        sleep_req |-> !wdt_clear && !file_we ##1 !sleep_req [*3])
        else $error("standby pulse malformed");
    a_wdt_alone: assert property (
        wdt_clear |-> !sleep_req && !file_we ##1 !wdt_clear [*3])
        else $error("watchdog pulse malformed");
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 16'h0000) else $error("read data not idle");
    a_unmapped_read: assert property (
        reg_rd && reg_addr[2] |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_status_reserved: assert property (
        reg_rd && reg_addr == 3'h2 |=> reg_rdata[15:6] == 10'h000)
        else $error("status upper bits set");

    c_port_write: cover property (file_we && file_addr == 7'h06);
    c_sleep: cover property (sleep_req);
    c_psc: cover property (psc_clear);
    c_call: cover property ($changed(prog_addr) && prog_addr == 13'h0010);
endmodule : midrange_decoder_sva

bind midrange_instruction_decoder midrange_decoder_sva chk_u (
    .clk(clk), .rst_n(rst_n), .prog_addr(prog_addr), .file_addr(file_addr),
    .file_we(file_we), .psc_to_timer0(psc_to_timer0),
    .psc_clear(psc_clear), .sleep_req(sleep_req), .wdt_clear(wdt_clear),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

//--- verification/prog_file_model.sv
`timescale 1ns/100ps
`default_nettype none
module prog_file_model (
    input wire logic clk, // clock
    input wire logic [12:0] prog_addr, // program address
    output logic [13:0] prog_data, // instruction word
    input wire logic [6:0] file_addr, // file address
    output logic [7:0] file_rdata, // file read data
    input wire logic [7:0] file_wdata, // file write data
    input wire logic file_we, // file write strobe
    input wire logic sleep_req, // standby pulse
    input wire logic wdt_clear, // watchdog pulse
    input wire logic psc_clear // prescaler clear pulse
);
    logic [13:0] rom [0:8191];
    logic [7:0] mem [0:127];
    int wt [0:127];
    int cyc = 0;
    logic [1:0] n_sleep = 2'h0;
    logic [1:0] n_wdt = 2'h0;
    logic [1:0] n_psc = 2'h0;
    initial begin
        foreach (rom[i]) rom[i] = 14'h0000;
        foreach (mem[i]) mem[i] = 8'h00;
    end
    // Whole words as loaded; the bench sets don't-care bits on purpose.
    assign prog_data = rom[prog_addr];
    assign file_rdata = mem[file_addr];
    // Write times let the bench measure instruction cycle spacing.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (file_we) begin
            mem[file_addr] <= file_wdata;
            wt[file_addr] <= cyc;
        end
        if (sleep_req) n_sleep <= n_sleep + 2'h1;
        if (wdt_clear) n_wdt <= n_wdt + 2'h1;
        if (psc_clear) n_psc <= n_psc + 2'h1;
    end
endmodule : prog_file_model
`default_nettype wire

//--- verification/midrange_instruction_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none
module midrange_instruction_decoder_tb;
    import midrange_core_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [12:0] prog_addr;
    word_t prog_data;
    logic [6:0] file_addr;
    byte_t file_rdata;
    logic [7:0] file_wdata;
    logic file_we, psc_clear, sleep_req, wdt_clear;
    byte_t port_pins = 8'hA5;
    logic psc_to_timer0 = 1'b1;
    bus_addr_t reg_addr = 3'h0;
    bus_data_t reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata, rd, pc;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;

    always #10 clk = ~clk;

    midrange_instruction_decoder dut_u (.clk(clk), .rst_n(rst_n),
        .prog_addr(prog_addr), .prog_data(prog_data), .file_addr(file_addr),
        .file_rdata(file_rdata), .file_wdata(file_wdata), .file_we(file_we),
        .port_pins(port_pins), .psc_to_timer0(psc_to_timer0),
        .psc_clear(psc_clear), .sleep_req(sleep_req), .wdt_clear(wdt_clear),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    prog_file_model model_u (.clk(clk), .prog_addr(prog_addr),
        .prog_data(prog_data), .file_addr(file_addr), .file_rdata(file_rdata),
        .file_wdata(file_wdata), .file_we(file_we), .sleep_req(sleep_req),
        .wdt_clear(wdt_clear), .psc_clear(psc_clear));

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task stop_test;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // Generous ceiling; a full run needs a little over two thousand cycles.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            error_cnt++;
            stop_test();
        end
    end

    task bus_wr(input bus_addr_t a, input bus_data_t d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : bus_wr

    task bus_rd(input bus_addr_t a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : bus_rd

    // Memories are loaded only once reset has stopped all file writes.
    task hold;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        model_u.n_sleep = 2'h0;
        model_u.n_wdt = 2'h0;
        model_u.n_psc = 2'h0;
    endtask : hold

    task start(input int n);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (n) @(posedge clk);
    endtask : start

    task t_regs;
        hold();
        start(0);
        bus_rd(3'h0, rd);
        check("ctrl", rd, 16'h0001);
        bus_rd(3'h2, rd);
        check("status", rd, 16'h0018);
        bus_wr(3'h2, 16'hFFFF);
        bus_rd(3'h2, rd);
        check("status ro", rd, 16'h0018);
        bus_rd(3'h5, rd);
        check("unmapped", rd, 16'h0000);
        bus_wr(3'h0, 16'h0000);
        repeat (8) @(posedge clk);
        bus_rd(3'h3, pc);
        repeat (20) @(posedge clk);
        bus_rd(3'h3, rd);
        check("halted pc", rd, pc);
        bus_wr(3'h0, 16'h0001);
        repeat (20) @(posedge clk);
        bus_rd(3'h3, rd);
        check("pc moves", {15'h0000, rd == pc}, 16'h0000);
        $display("registers done");
    endtask : t_regs

    // C, DC and Z are preset to ones first, so untouched flags stay visible.
    task t_exec(input word_t w, input byte_t m, a0, ea, em, st,
                input logic [5:0] pl = 6'h00);
        hold();
        model_u.rom[0] = 14'h3001;
        model_u.rom[1] = 14'h3EFF;
        model_u.rom[2] = {6'h30, a0};
        model_u.rom[3] = w;
        model_u.rom[4] = 14'h2804;
        model_u.rom[5] = 14'h2805;
        model_u.mem[w[6:0]] = m;
        start(40);
        bus_rd(3'h1, rd);
        check("acc", rd, {8'h00, ea});
        bus_rd(3'h2, rd);
        check("status", rd, {8'h00, st});
        check("file", {8'h00, model_u.mem[w[6:0]]}, {8'h00, em});
        check("pulses", {10'h000, model_u.n_psc, model_u.n_wdt,
              model_u.n_sleep}, {10'h000, pl});
        $display("exec %h done", w);
    endtask : t_exec

    task t_skip(input word_t w, input byte_t m, input logic skip);
        hold();
        model_u.rom[0] = 14'h305A;
        model_u.rom[1] = 14'h00A1;
        model_u.rom[2] = w;
        model_u.rom[3] = 14'h00A2;
        model_u.rom[4] = 14'h00A3;
        model_u.rom[5] = 14'h2805;
        model_u.mem[7'h20] = m;
        model_u.mem[7'h22] = 8'h00;
        start(48);
        check("skipped", {8'h00, model_u.mem[7'h22]},
              skip ? 16'h0000 : 16'h005A);
        check("skip gap", 16'(model_u.wt[7'h23] - model_u.wt[7'h21]),
              16'h000C);
        $display("skip %h done", w);
    endtask : t_skip

    task t_call(input word_t ret, input byte_t em, st);
        hold();
        model_u.rom[0] = 14'h00A1;
        model_u.rom[1] = 14'h2010;
        model_u.rom[2] = 14'h00A3;
        model_u.rom[3] = 14'h2803;
        model_u.rom[16] = 14'h3066;
        model_u.rom[17] = ret;
        start(60);
        check("returned", {8'h00, model_u.mem[7'h23]}, {8'h00, em});
        check("call gap", 16'(model_u.wt[7'h23] - model_u.wt[7'h21]),
              16'h0018);
        bus_rd(3'h2, rd);
        check("status", rd, {8'h00, st});
        $display("call %h done", ret);
    endtask : t_call

    initial begin
        repeat (2) @(posedge clk);
        t_regs();
        t_exec(14'h07A0, 8'h0F, 8'h01, 8'h01, 8'h10, 8'h1A);
        t_exec(14'h0220, 8'h05, 8'h06, 8'hFF, 8'h05, 8'h18);
        t_exec(14'h0520, 8'hF0, 8'h0F, 8'h00, 8'hF0, 8'h1F);
        t_exec(14'h04A0, 8'h50, 8'h0A, 8'h0A, 8'h5A, 8'h1B);
        t_exec(14'h0620, 8'hFF, 8'h0F, 8'hF0, 8'hFF, 8'h1B);
        t_exec(14'h0BA0, 8'h01, 8'h77, 8'h77, 8'h00, 8'h1F);
        t_exec(14'h0F20, 8'hFE, 8'h77, 8'hFF, 8'hFE, 8'h1F);
        t_exec(14'h03A0, 8'h02, 8'h77, 8'h77, 8'h01, 8'h1B);
        t_exec(14'h0A20, 8'h10, 8'h77, 8'h11, 8'h10, 8'h1B);
        t_exec(14'h09A0, 8'h0F, 8'h77, 8'h77, 8'hF0, 8'h1B);
        t_exec(14'h0820, 8'h33, 8'h77, 8'h33, 8'h33, 8'h1B);
        t_exec(14'h0DA0, 8'h41, 8'h77, 8'h77, 8'h83, 8'h1E);
        t_exec(14'h0C20, 8'h02, 8'h77, 8'h81, 8'h02, 8'h1E);
        t_exec(14'h0EA0, 8'h3C, 8'h77, 8'h77, 8'hC3, 8'h1F);
        t_exec(14'h01A0, 8'h55, 8'h77, 8'h77, 8'h00, 8'h1F);
        t_exec(14'h017F, 8'h55, 8'h77, 8'h00, 8'h55, 8'h1F);
        t_exec(14'h00A0, 8'h55, 8'h77, 8'h77, 8'h77, 8'h1F);
        t_exec(14'h0080, 8'h00, 8'h77, 8'h77, 8'h77, 8'h1F);
        t_exec(14'h11A0, 8'hFF, 8'h77, 8'h77, 8'hF7, 8'h1F);
        t_exec(14'h1720, 8'h00, 8'h77, 8'h77, 8'h40, 8'h1F);
        t_exec(14'h1486, 8'h00, 8'h77, 8'h77, 8'hA7, 8'h1F);
        t_exec(14'h0081, 8'h00, 8'h77, 8'h77, 8'h77, 8'h1F, 6'h10);
        @(posedge clk);
        psc_to_timer0 <= 1'b0;
        t_exec(14'h0081, 8'h00, 8'h77, 8'h77, 8'h77, 8'h1F);
        @(posedge clk);
        psc_to_timer0 <= 1'b1;
        t_exec(14'h3C05, 8'h00, 8'h03, 8'h02, 8'h00, 8'h1B);
        t_exec(14'h39FF, 8'h00, 8'h3C, 8'h3C, 8'h00, 8'h1B);
        t_exec(14'h3801, 8'h00, 8'h00, 8'h01, 8'h00, 8'h1B);
        t_exec(14'h3AFF, 8'h00, 8'h0F, 8'hF0, 8'h00, 8'h1B);
        t_exec(14'h3F08, 8'h00, 8'h08, 8'h10, 8'h00, 8'h1A);
        t_exec(14'h0063, 8'h00, 8'h77, 8'h77, 8'h00, 8'h17, 6'h01);
        t_exec(14'h0064, 8'h00, 8'h77, 8'h77, 8'h00, 8'h1F, 6'h04);
        t_exec(14'h0060, 8'h00, 8'h77, 8'h77, 8'h00, 8'h1F);
        t_skip(14'h1C20, 8'h01, 1'b1);
        t_skip(14'h1C20, 8'h00, 1'b0);
        t_skip(14'h1BA0, 8'h00, 1'b1);
        t_skip(14'h1BA0, 8'h80, 1'b0);
        t_skip(14'h0BA0, 8'h01, 1'b1);
        t_skip(14'h0BA0, 8'h02, 1'b0);
        t_skip(14'h0FA0, 8'hFF, 1'b1);
        t_call(14'h3777, 8'h77, 8'h18);
        t_call(14'h0008, 8'h66, 8'h18);
        t_call(14'h0009, 8'h66, 8'h38);
        stop_test();
    end
endmodule : midrange_instruction_decoder_tb
`default_nettype wire
